// ---- hw/evt_timer_consts.vh ----
// constants of the 8-bit timer/event counter and its register map
`ifndef EVT_TIMER_CONSTS_VH
`define EVT_TIMER_CONSTS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_EVENT_COUNT_VALUE      4'h0
`define OFS_COMPARE_VALUE_REGISTER 4'h4
`define OFS_COUNT_SOURCE_SELECT    4'h8
`define OFS_TIMER_MODE_CONTROL     4'hC
`define ADDR_WIDTH                 4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_COMPARE                8'h00
`define RST_SOURCE_SELECT          3'h0
`define RST_COUNT                  8'h00

// ----------------------------------------------------------------
// timer mode control bit positions
// ----------------------------------------------------------------
`define BIT_COUNT_RUN              7
`define BIT_PWM_MODE_SELECT        6
`define BIT_OUTPUT_PRESET_HIGH     3
`define BIT_OUTPUT_PRESET_LOW      2
`define BIT_LEVEL_OR_TOGGLE        1
`define BIT_OUTPUT_DRIVE_ENABLE    0

// ----------------------------------------------------------------
// count source encodings and counter values
// ----------------------------------------------------------------
`define SRC_EVENT_FALLING          3'h0
`define SRC_EVENT_RISING           3'h1
`define SRC_FIRST_PRESCALED        3'h2
`define COUNT_MAX                  8'hFF
`define COUNT_BEFORE_MAX           8'hFE
`define PRESCALE_WIDTH             5

// ----------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------
`define RESP_OKAY                  2'h0
`define RESP_SLVERR                2'h2

`endif

// ---- hw/event_edge_sync.v ----
// three-stage synchroniser with single-cycle edge pulses
`timescale 1ns/1ps
module event_edge_sync (
    input  wire clk_i,
    input  wire rst_b_i,
    input  wire pin_i,
    output wire rise_o,
    output wire fall_o
);
    reg stage1;
    reg stage2;
    reg stage3;
    reg settled;

    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            stage1 <= 1'b0;
            stage2 <= 1'b0;
            stage3  <= 1'b0;
            settled <= 1'b0;
        end
        else
        begin
            stage1 <= pin_i;
            stage2 <= stage1;
            stage3 <= stage2;
            if (stage2 == stage3)
                settled <= stage3;
        end
    end

    // a change counts once stage 2 and stage 3 agree on a level other than the settled one
    assign rise_o = stage2 & stage3 & ~settled;
    assign fall_o = ~stage2 & ~stage3 & settled;
endmodule // event_edge_sync

// ---- hw/count_prescaler.v ----
// free-running prescaler giving one-cycle ticks at clk/1 .. clk/32
`timescale 1ns/1ps
module count_prescaler #(
    parameter WIDTH = 5
) (
    input  wire       clk_i,
    input  wire       rst_b_i,
    input  wire [2:0] divide_log2_i,
    output reg        tick_o
);
    reg  [WIDTH-1:0] div_count;
    wire [WIDTH-1:0] mask;

    always @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
            div_count <= {WIDTH{1'b0}};
        else
            div_count <= div_count + {{(WIDTH-1){1'b0}}, 1'b1};
    end

    // a tick whenever the low divide_log2 bits are all ones
    assign mask = ~({WIDTH{1'b1}} << divide_log2_i);

    always @*
    begin
        tick_o = ((div_count & mask) == mask);
    end
endmodule // count_prescaler

// ---- hw/event_timer.v ----
// 8-bit timer/event counter with an AXI4-Lite register slave
//
// Contract
// [R1] clear-start: match raises interrupt, clears counter
// [R2] interval period is compare plus one clocks
// [R3] run bit starts and stops counting
// [R4] event mode counts selected event edge
// [R5] low three select bits choose count source
// [R6] square wave toggles output on each match
// [R7] square frequency is count clock over 2(N+1)
// [R8] preset bits set initial output level
// [R9] mode bit 6 selects pwm output
// [R10] pwm inactive from start until first overflow
// [R11] overflow drives active level until match
// [R12] match drives inactive level until next overflow
// [R13] stopping in pwm forces inactive level
// [R14] bit 1 picks pwm active level
// [R15] bit 0 enables timer output drive
// [R16] pwm compare reload at next or second overflow
// [R17] compare read returns newest written value
// [R18] software spaces pwm compare writes three clocks
// [R19] software keeps compare fixed while running
// [R20] first match may be one clock off
// [R21] run bit zero clears and holds counter
// [R22] match interrupts only outside pwm mode
// [R23] pwm counter wraps, wrap is the overflow
// [R24] event edge synchronised into one-cycle pulse
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "evt_timer_consts.vh"
module event_timer (
    input  wire        CLOCK_I,
    input  wire        RST_B_I,
    input  wire [3:0]  S_AXI_AWADDR_I,
    input  wire        S_AXI_AWVALID_I,
    output wire        S_AXI_AWREADY_O,
    input  wire [31:0] S_AXI_WDATA_I,
    input  wire [3:0]  S_AXI_WSTRB_I,
    input  wire        S_AXI_WVALID_I,
    output wire        S_AXI_WREADY_O,
    output reg  [1:0]  S_AXI_BRESP_O,
    output reg         S_AXI_BVALID_O,
    input  wire        S_AXI_BREADY_I,
    input  wire [3:0]  S_AXI_ARADDR_I,
    input  wire        S_AXI_ARVALID_I,
    output wire        S_AXI_ARREADY_O,
    output reg  [31:0] S_AXI_RDATA_O,
    output reg  [1:0]  S_AXI_RRESP_O,
    output reg         S_AXI_RVALID_O,
    input  wire        S_AXI_RREADY_I,
    input  wire        EVENT_INPUT_PIN_I,
    output reg         TIMER_OUTPUT_PIN_O,
    output reg         MATCH_INTERRUPT_O
);
    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    reg  [7:0]  event_count_value;
    reg  [7:0]  compare_value_register;
    reg  [7:0]  compare_in_use;
    reg  [2:0]  count_source_select;
    reg         count_run_bit;
    reg         pwm_mode_select;
    reg         level_or_toggle_select;
    reg         output_drive_enable;
    reg         output_ff;
    reg         pwm_active;
    reg         reload_pending;
    reg         reload_armed;

    reg  [3:0]  aw_addr;
    reg         aw_held;
    reg  [7:0]  w_data;
    reg         w_lane0;
    reg         w_held;

    wire        event_rise;
    wire        event_fall;
    wire        prescale_tick;
    reg         count_tick;
    wire        do_write;
    wire        write_compare;
    wire        write_mode;
    wire        write_source;
    wire        match;
    wire        overflow;

    // ----------------------------------------------------------------
    // count source
    // ----------------------------------------------------------------
    event_edge_sync u_event_sync (
        .clk_i   (CLOCK_I),
        .rst_b_i (RST_B_I),
        .pin_i   (EVENT_INPUT_PIN_I),
        .rise_o  (event_rise),
        .fall_o  (event_fall)
    ); // see [R24]

    count_prescaler #(
        .WIDTH (`PRESCALE_WIDTH)
    ) u_prescaler (
        .clk_i         (CLOCK_I),
        .rst_b_i       (RST_B_I),
        .divide_log2_i (count_source_select - `SRC_FIRST_PRESCALED),
        .tick_o        (prescale_tick)
    ); // see [R20]

    always @*
    begin
        if (count_source_select == `SRC_EVENT_FALLING)
            count_tick = event_fall; // see [R4]
        else if (count_source_select == `SRC_EVENT_RISING)
            count_tick = event_rise; // see [R4]
        else
            count_tick = prescale_tick; // see [R5]
    end

    // ----------------------------------------------------------------
    // bus write side
    // ----------------------------------------------------------------
    assign S_AXI_AWREADY_O = ~aw_held & ~S_AXI_BVALID_O;
    assign S_AXI_WREADY_O  = ~w_held & ~S_AXI_BVALID_O;
    assign do_write        = aw_held & w_held & ~S_AXI_BVALID_O;
    assign write_compare   = do_write & w_lane0 & (aw_addr == `OFS_COMPARE_VALUE_REGISTER);
    assign write_source    = do_write & w_lane0 & (aw_addr == `OFS_COUNT_SOURCE_SELECT);
    assign write_mode      = do_write & w_lane0 & (aw_addr == `OFS_TIMER_MODE_CONTROL);

    always @(posedge CLOCK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            aw_held        <= 1'b0;
            aw_addr        <= 4'h0;
            w_held         <= 1'b0;
            w_data         <= 8'h00;
            w_lane0        <= 1'b0;
            S_AXI_BVALID_O <= 1'b0;
            S_AXI_BRESP_O  <= `RESP_OKAY;
        end
        else
        begin
            if (S_AXI_AWVALID_I && S_AXI_AWREADY_O)
            begin
                aw_held <= 1'b1;
                aw_addr <= {S_AXI_AWADDR_I[3:2], 2'b00};
            end
            if (S_AXI_WVALID_I && S_AXI_WREADY_O)
            begin
                w_held  <= 1'b1;
                w_data  <= S_AXI_WDATA_I[7:0];
                w_lane0 <= S_AXI_WSTRB_I[0];
            end
            if (do_write)
            begin
                aw_held        <= 1'b0;
                w_held         <= 1'b0;
                S_AXI_BVALID_O <= 1'b1;
                S_AXI_BRESP_O  <= `RESP_OKAY;
                if (aw_addr == `OFS_EVENT_COUNT_VALUE)
                    S_AXI_BRESP_O <= `RESP_SLVERR;
            end
            else if (S_AXI_BVALID_O && S_AXI_BREADY_I)
                S_AXI_BVALID_O <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // bus read side
    // ----------------------------------------------------------------
    assign S_AXI_ARREADY_O = ~S_AXI_RVALID_O;

    always @(posedge CLOCK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            S_AXI_RVALID_O <= 1'b0;
            S_AXI_RDATA_O  <= 32'h00000000;
            S_AXI_RRESP_O  <= `RESP_OKAY;
        end
        else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O)
        begin
            S_AXI_RVALID_O <= 1'b1;
            S_AXI_RRESP_O  <= `RESP_OKAY;
            S_AXI_RDATA_O  <= 32'h00000000;
            if ({S_AXI_ARADDR_I[3:2], 2'b00} == `OFS_EVENT_COUNT_VALUE)
                S_AXI_RDATA_O[7:0] <= event_count_value;
            else if ({S_AXI_ARADDR_I[3:2], 2'b00} == `OFS_COMPARE_VALUE_REGISTER)
                S_AXI_RDATA_O[7:0] <= compare_value_register; // see [R17]
            else if ({S_AXI_ARADDR_I[3:2], 2'b00} == `OFS_COUNT_SOURCE_SELECT)
                S_AXI_RDATA_O[2:0] <= count_source_select;
            else
                // preset bits are write only and read as zero
                S_AXI_RDATA_O[7:0] <= {count_run_bit, pwm_mode_select, 4'h0,
                                       level_or_toggle_select, output_drive_enable};
        end
        else if (S_AXI_RVALID_O && S_AXI_RREADY_I)
            S_AXI_RVALID_O <= 1'b0;
    end

    // ----------------------------------------------------------------
    // configuration
    // ----------------------------------------------------------------
    always @(posedge CLOCK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            compare_value_register <= `RST_COMPARE;
            count_source_select    <= `RST_SOURCE_SELECT;
            count_run_bit          <= 1'b0;
            pwm_mode_select        <= 1'b0;
            level_or_toggle_select <= 1'b0;
            output_drive_enable    <= 1'b0;
        end
        else
        begin
            if (write_compare)
                compare_value_register <= w_data;
            if (write_source)
                count_source_select <= w_data[2:0]; // see [R5]
            if (write_mode)
            begin
                count_run_bit          <= w_data[`BIT_COUNT_RUN]; // see [R3]
                pwm_mode_select        <= w_data[`BIT_PWM_MODE_SELECT]; // see [R9]
                level_or_toggle_select <= w_data[`BIT_LEVEL_OR_TOGGLE]; // see [R14]
                output_drive_enable    <= w_data[`BIT_OUTPUT_DRIVE_ENABLE]; // see [R15]
            end
        end
    end

    // ----------------------------------------------------------------
    // counter and compare
    // ----------------------------------------------------------------
    assign match    = count_run_bit & count_tick & (event_count_value == compare_in_use);
    assign overflow = count_run_bit & count_tick & (event_count_value == `COUNT_MAX);

    always @(posedge CLOCK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            event_count_value <= `RST_COUNT;
            MATCH_INTERRUPT_O <= 1'b0;
        end
        else
        begin
            MATCH_INTERRUPT_O <= match & ~pwm_mode_select; // see [R22]
            if (!count_run_bit)
                event_count_value <= `RST_COUNT; // see [R21]
            else if (match && !pwm_mode_select)
                event_count_value <= `RST_COUNT; // see [R1] [R2]
            else if (count_tick)
                event_count_value <= event_count_value + 8'h01; // see [R23]
        end
    end

    // pwm compare reload: armed only if the write came before count FF
    always @(posedge CLOCK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            compare_in_use <= `RST_COMPARE;
            reload_pending <= 1'b0;
            reload_armed   <= 1'b0;
        end
        else if (!pwm_mode_select || !count_run_bit)
        begin
            compare_in_use <= write_compare ? w_data : compare_value_register;
            reload_pending <= 1'b0;
            reload_armed   <= 1'b0;
        end
        else
        begin
            if (count_tick && event_count_value == `COUNT_BEFORE_MAX)
                reload_armed <= reload_pending | write_compare; // see [R16]
            if (overflow && reload_armed)
            begin
                compare_in_use <= compare_value_register; // see [R16]
                reload_armed   <= 1'b0;
                reload_pending <= write_compare;
            end
            else if (write_compare)
                reload_pending <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // timer output
    // ----------------------------------------------------------------
    always @(posedge CLOCK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            output_ff  <= 1'b0;
            pwm_active <= 1'b0;
        end
        else
        begin
            if (!pwm_mode_select && write_mode &&
                w_data[`BIT_OUTPUT_PRESET_HIGH] && !w_data[`BIT_OUTPUT_PRESET_LOW])
                output_ff <= 1'b1; // see [R8]
            else if (!pwm_mode_select && write_mode &&
                     !w_data[`BIT_OUTPUT_PRESET_HIGH] && w_data[`BIT_OUTPUT_PRESET_LOW])
                output_ff <= 1'b0; // see [R8]
            else if (!pwm_mode_select && match && level_or_toggle_select)
                output_ff <= ~output_ff; // see [R6] [R7]

            if (!count_run_bit || !pwm_mode_select)
                pwm_active <= 1'b0; // see [R10] [R13]
            else if (overflow)
                pwm_active <= 1'b1; // see [R11]
            else if (match)
                pwm_active <= 1'b0; // see [R12]
        end
    end

    always @(posedge CLOCK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
            TIMER_OUTPUT_PIN_O <= 1'b0;
        else if (!output_drive_enable)
            TIMER_OUTPUT_PIN_O <= 1'b0; // see [R15]
        else if (pwm_mode_select)
            TIMER_OUTPUT_PIN_O <= pwm_active ^ level_or_toggle_select; // see [R9] [R14]
        else
            TIMER_OUTPUT_PIN_O <= output_ff;
    end
endmodule // event_timer

// ---- testbench/event_timer_properties.sv ----
// bus and match checks on the timer ports
`timescale 1ns/1ps
module event_timer_properties (
    input wire        CLOCK_I,
    input wire        RST_B_I,
    input wire [3:0]  S_AXI_AWADDR_I,
    input wire        S_AXI_AWVALID_I,
    input wire        S_AXI_AWREADY_O,
    input wire        S_AXI_WVALID_I,
    input wire        S_AXI_WREADY_O,
    input wire [1:0]  S_AXI_BRESP_O,
    input wire        S_AXI_BVALID_O,
    input wire        S_AXI_BREADY_I,
    input wire        S_AXI_ARVALID_I,
    input wire        S_AXI_ARREADY_O,
    input wire [31:0] S_AXI_RDATA_O,
    input wire [1:0]  S_AXI_RRESP_O,
    input wire        S_AXI_RVALID_O,
    input wire        S_AXI_RREADY_I,
    input wire        MATCH_INTERRUPT_O
);
    reg [3:0] aw_addr;
    default clocking @(posedge CLOCK_I); endclocking
    default disable iff (!RST_B_I);
    always @(posedge CLOCK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
            aw_addr <= 4'h0;
        else if (S_AXI_AWVALID_I && S_AXI_AWREADY_O)
            aw_addr <= S_AXI_AWADDR_I;
    end
    sequence both_taken;
        S_AXI_AWVALID_I && S_AXI_AWREADY_O && S_AXI_WVALID_I && S_AXI_WREADY_O;
    endsequence
    sequence read_taken;
        S_AXI_ARVALID_I && S_AXI_ARREADY_O;
    endsequence
    write_answer_a: assert property (both_taken |-> ##[1:2] S_AXI_BVALID_O)
        else $error("write answer missing");
    write_hold_a: assert property (S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O))
        else $error("write answer dropped");
    write_code_a: assert property (S_AXI_BVALID_O |-> S_AXI_BRESP_O == (aw_addr[3:2] == 2'h0 ? 2'h2 : 2'h0))
        else $error("write answer code wrong");
    write_block_a: assert property (S_AXI_BVALID_O |-> !S_AXI_AWREADY_O && !S_AXI_WREADY_O)
        else $error("write taken while answering");
    read_answer_a: assert property (read_taken |=> S_AXI_RVALID_O)
        else $error("read answer missing");
    read_hold_a: assert property (S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O))
        else $error("read answer dropped");
    read_block_a: assert property (S_AXI_RVALID_O |-> !S_AXI_ARREADY_O)
        else $error("read taken while answering");
    read_word_a: assert property (S_AXI_RVALID_O |-> S_AXI_RDATA_O[31:8] == 24'h0 && S_AXI_RRESP_O == 2'h0)
        else $error("read word malformed");
    match_pulse_a: assert property ($rose(MATCH_INTERRUPT_O) |=> !MATCH_INTERRUPT_O)
        else $error("match pulse too long");
endmodule // event_timer_properties

bind event_timer event_timer_properties i_props (.CLOCK_I(CLOCK_I), .RST_B_I(RST_B_I),
    .S_AXI_AWADDR_I(S_AXI_AWADDR_I), .S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O),
    .S_AXI_WVALID_I(S_AXI_WVALID_I), .S_AXI_WREADY_O(S_AXI_WREADY_O), .S_AXI_BRESP_O(S_AXI_BRESP_O),
    .S_AXI_BVALID_O(S_AXI_BVALID_O), .S_AXI_BREADY_I(S_AXI_BREADY_I), .S_AXI_ARVALID_I(S_AXI_ARVALID_I),
    .S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_RDATA_O(S_AXI_RDATA_O), .S_AXI_RRESP_O(S_AXI_RRESP_O),
    .S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I), .MATCH_INTERRUPT_O(MATCH_INTERRUPT_O));

// ---- testbench/event_pulse_source.sv ----
// event pin source: one pin edge per request, levels kept wide
`timescale 1ns/1ps
module event_pulse_source (
    input  wire clk_i,
    input  wire go_i,
    output reg  pin_o
);
    reg [2:0] hold = 3'h0;
    initial pin_o = 1'h0;
    // edge comes four clocks after the request, so each level lasts well over two clocks
    always @(posedge clk_i)
    begin
        if (go_i && hold == 3'h0)
            hold <= 3'h4;
        else if (hold != 3'h0)
            hold <= hold - 3'h1;
        if (hold == 3'h1)
            pin_o <= ~pin_o;
    end
endmodule // event_pulse_source

// ---- testbench/event_timer_tb_top.sv ----
// self-checking bench for the timer/event counter
`timescale 1ns/1ps
module event_timer_tb_top;
    reg         clk = 1'h0;
    reg         rst_b = 1'h0;
    reg  [3:0]  awaddr = 4'h0;
    reg  [3:0]  araddr = 4'h0;
    reg  [31:0] wdata = 32'h0;
    reg         awvalid = 1'h0;
    reg         wvalid = 1'h0;
    reg         bready = 1'h0;
    reg         arvalid = 1'h0;
    reg         rready = 1'h0;
    reg         go = 1'h0;
    wire        awready, wready, bvalid, arready, rvalid, pin, irq, evt;
    wire [1:0]  bresp, rresp;
    wire [31:0] rdata;
    integer     fails = 0;
    integer     samples_checked = 0;
    integer     irqs = 0;
    integer     s, g, h, j;

    always #50 clk = ~clk;
    always @(posedge clk)
        if (irq === 1'h1)
            irqs <= irqs + 1;

    event_timer i_dut (.CLOCK_I(clk), .RST_B_I(rst_b), .S_AXI_AWADDR_I(awaddr), .S_AXI_AWVALID_I(awvalid),
        .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata), .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wvalid),
        .S_AXI_WREADY_O(wready), .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
        .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
        .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid), .S_AXI_RREADY_I(rready),
        .EVENT_INPUT_PIN_I(evt), .TIMER_OUTPUT_PIN_O(pin), .MATCH_INTERRUPT_O(irq));
    event_pulse_source i_src (.clk_i(clk), .go_i(go), .pin_o(evt));

    // ----------------------------------------
    // bus tasks and compares
    // ----------------------------------------
    task check(input string nm, input [31:0] exp, input [31:0] got);
    begin
        samples_checked = samples_checked + 1;
        if (got !== exp)
        begin
            fails = fails + 1;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    end
    endtask
    // handshakes are judged at the falling edge, acted on at the next rising edge
    task wr(input [3:0] a, input [7:0] d, input [1:0] er);
        reg ta, tw, tb;
        reg [1:0] r;
        integer n;
    begin
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        n = 0;
        tb = 1'h0;
        while (!tb && n < 60)
        begin
            @(negedge clk);
            ta = awvalid & awready;
            tw = wvalid & wready;
            tb = bvalid;
            r = bresp;
            @(posedge clk);
            if (ta)
                awvalid <= 1'h0;
            if (tw)
                wvalid <= 1'h0;
            n = n + 1;
        end
        bready <= 1'h0;
        check("bdone", 1, tb);
        check("bresp", er, r);
    end
    endtask
    task rchk(input [3:0] a, input [31:0] exp);
        reg t, ta;
        reg [31:0] d;
        integer n;
    begin
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        n = 0;
        t = 1'h0;
        while (!t && n < 60)
        begin
            @(negedge clk);
            ta = arvalid & arready;
            t = rvalid;
            d = rdata;
            @(posedge clk);
            if (ta)
                arvalid <= 1'h0;
            n = n + 1;
        end
        rready <= 1'h0;
        check("rdone", 1, t);
        check("rdata", exp, d);
    end
    endtask
    // cycles from one rise of the pin (sel 1) or match line to the next, and high cycles between
    task gap(input sel, output integer gl, output integer hl);
        reg p, v;
        integer e, n;
    begin
        @(negedge clk);
        p = sel ? pin : irq;
        e = 0;
        gl = 0;
        hl = 0;
        n = 0;
        while (e < 2 && n < 3000)
        begin
            @(negedge clk);
            v = sel ? pin : irq;
            if (v === 1'h1 && p !== 1'h1)
                e = e + 1;
            if (e == 1)
            begin
                gl = gl + 1;
                hl = hl + (v === 1'h1);
            end
            p = v;
            n = n + 1;
        end
    end
    endtask
    task pin_is(input [31:0] exp);
    begin
        repeat (4) @(negedge clk);
        check("pin", exp, pin);
    end
    endtask
    task evt_edge;
    begin
        @(posedge clk);
        go <= 1'h1;
        @(posedge clk);
        go <= 1'h0;
        repeat (12) @(posedge clk);
    end
    endtask
    task test_done;
    begin
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    end
    endtask

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin
        #4000000;
        fails = fails + 1;
        test_done;
    end
    initial
    begin
        repeat (5) @(posedge clk);
        rst_b <= 1'h1;
        for (s = 0; s < 4; s = s + 1)
            rchk(s * 4, 32'h0);
        wr(4'h0, 8'h05, 2'h2);
        $display("test reset values done");
        wr(4'h4, 8'h01, 2'h0);
        for (s = 2; s < 8; s = s + 1)
        begin
            wr(4'hC, 8'h00, 2'h0);
            wr(4'h8, s, 2'h0);
            wr(4'hC, 8'h80, 2'h0);
            gap(1'h0, g, h);
            check("irq gap", 2 << (s - 2), g);
            check("irq width", 1, h);
        end
        wr(4'hC, 8'h00, 2'h0);
        rchk(4'h0, 32'h0);
        j = irqs;
        repeat (100) @(posedge clk);
        check("irq stopped", j, irqs);
        $display("test interval done");
        wr(4'h4, 8'h05, 2'h0);
        for (s = 0; s < 2; s = s + 1)
        begin
            wr(4'hC, 8'h00, 2'h0);
            wr(4'h8, s, 2'h0);
            wr(4'hC, 8'h80, 2'h0);
            evt_edge;
            rchk(4'h0, s);
            evt_edge;
            rchk(4'h0, 32'h1);
        end
        $display("test events done");
        wr(4'hC, 8'h00, 2'h0);
        wr(4'h4, 8'h04, 2'h0);
        wr(4'h8, 8'h02, 2'h0);
        wr(4'hC, 8'h0B, 2'h0);
        pin_is(1);
        wr(4'hC, 8'h07, 2'h0);
        pin_is(0);
        wr(4'hC, 8'h83, 2'h0);
        gap(1'h1, g, h);
        check("square period", 10, g);
        check("square high", 5, h);
        $display("test square done");
        wr(4'hC, 8'h00, 2'h0);
        wr(4'h4, 8'h40, 2'h0);
        wr(4'hC, 8'h41, 2'h0);
        pin_is(0);
        j = irqs;
        wr(4'hC, 8'hC1, 2'h0);
        gap(1'h1, g, h);
        check("pwm period", 256, g);
        check("pwm high", 65, h);
        wr(4'h4, 8'h20, 2'h0);
        rchk(4'h4, 32'h20);
        gap(1'h1, g, h);
        gap(1'h1, g, h);
        check("pwm reload", 33, h);
        check("pwm irqs", j, irqs);
        wr(4'hC, 8'hC3, 2'h0);
        gap(1'h1, g, h);
        gap(1'h1, g, h);
        check("pwm low", 223, h);
        wr(4'hC, 8'h43, 2'h0);
        pin_is(1);
        wr(4'hC, 8'h40, 2'h0);
        pin_is(0);
        $display("test pwm done");
        test_done;
    end
endmodule // event_timer_tb_top
